//--- pkg/cmb_pkg.sv
// Purpose: constants and types for the message buffer block
// Assumes: classic Wishbone, 32-bit data, one register per aligned word
// Notes: byte address is four times the word index
//
// Function
// R01: Extended identifier is 29 bits spread over four identifier words.
// R02: Extended identifier bit 28 is most significant and sent first.
// R03: Numerically smaller identifier has higher priority in both formats.
// R04: Extended word 2 holds identifier bits 14..7 in bits 7..0.
// R05: Extended word 3 holds identifier bits 6..0 in 7..1, remote flag bit 0.
// R06: Transmit remote flag clear sends data frame, set sends remote frame.
// R07: Receive buffer stores remote flag exactly as received.
// R08: Standard identifier is 11 bits, bit 10 most significant and sent first.
// R09: Standard word 0 holds identifier bits 10..3 in bits 7..0.
// R10: Standard word 1: id 2..0 in 7..5, remote bit 4, format bit 3.
// R11: Transmit format flag clear sends 11-bit, set sends 29-bit identifier.
// R12: Receive format flag is set according to the received frame.
// R13: Each buffer has eight byte-wide payload registers.
// R14: Length code governs how many payload bytes are sent or received.
// R15: Payload bytes beyond the count are ignored on send, unspecified on receive.
// R16: Extended word 0 holds id 28..21; word 1 id 20..18, substitute, format, 17..15.
// R17: Software writes substitute bit as 1 for transmit; received value is stored.
// R18: Length code 0000..1000 maps linearly to 0..8 bytes for data frames.
// R19: Remote frame sends the length code as programmed but zero payload bytes.

package cmb_pkg;

   // ----------------------------------------------------------------------
   // Word indices
   // ----------------------------------------------------------------------
   localparam logic [5:0] TX_BASE_IDX = 6'h00;
   localparam logic [5:0] RX_BASE_IDX = 6'h10;
   localparam logic [5:0] CTRL_IDX = 6'h20;
   localparam logic [5:0] STAT_IDX = 6'h21;

   // ----------------------------------------------------------------------
   // Buffer layout
   // ----------------------------------------------------------------------
   localparam int BUF_BYTES = 13;
   localparam logic [3:0] ID0_POS = 4'h0;
   localparam logic [3:0] ID1_POS = 4'h1;
   localparam logic [3:0] ID2_POS = 4'h2;
   localparam logic [3:0] ID3_POS = 4'h3;
   localparam logic [3:0] DATA0_POS = 4'h4;
   localparam logic [3:0] LEN_POS = 4'hC;
   localparam logic [3:0] LAST_POS = 4'hC;
   localparam int SRR_BIT = 4;
   localparam int IDE_BIT = 3;
   localparam int RTR_EXT_BIT = 0;
   localparam int RTR_STD_BIT = 4;
   localparam logic [3:0] MAX_COUNT = 4'h8;

   // ----------------------------------------------------------------------
   // Control and status bits
   // ----------------------------------------------------------------------
   localparam int CTRL_SEND_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int STAT_TX_PEND_BIT = 0;
   localparam int STAT_RX_FULL_BIT = 1;
   localparam int STAT_RX_OVR_BIT = 2;
   localparam int STAT_TX_BUSY_BIT = 3;

   // ----------------------------------------------------------------------
   // Arbitration field lengths
   // ----------------------------------------------------------------------
   localparam logic [5:0] ARB_LEN_EXT = 6'h20;
   localparam logic [5:0] ARB_LEN_STD = 6'h0D;

   typedef enum logic [2:0] {
      CMB_TX_IDLE = 3'h1,
      CMB_TX_PEND = 3'h2,
      CMB_TX_BUSY = 3'h4
   } cmb_tx_state_type;

endpackage

//--- logic/cmb_message_buffer.sv
// Purpose: one transmit and one receive message buffer behind Wishbone
// Assumes: protocol engine on the same clock, one-cycle pulses
// Notes: single clock, synchronous reset

`timescale 1ns/1ps

module cmb_message_buffer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Transmit side towards the protocol engine
   output logic tx_valid_o,
   input wire logic tx_take_i,
   input wire logic tx_done_i,
   output logic [28:0] tx_ident_o,
   output logic tx_ext_o,
   output logic tx_remote_o,
   output logic tx_srr_o,
   output logic [3:0] tx_len_code_o,
   output logic [3:0] tx_byte_count_o,
   output logic [63:0] tx_data_o,
   // Arbitration helpers
   output logic [28:0] tx_arb_key_o,
   input wire logic [28:0] contender_key_i,
   output logic tx_outranks_o,
   input wire logic arb_shift_i,
   output logic arb_bit_o,
   output logic [5:0] arb_bits_left_o,
   // Receive side from the protocol engine
   output logic rx_ready_o,
   input wire logic rx_store_i,
   input wire logic [28:0] rx_ident_i,
   input wire logic rx_ext_i,
   input wire logic rx_remote_i,
   input wire logic rx_srr_i,
   input wire logic [3:0] rx_len_code_i,
   input wire logic [63:0] rx_data_i
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [12:0][7:0] tx_buf;
      logic [12:0][7:0] rx_buf;
      cmb_pkg::cmb_tx_state_type tx_state;
      logic rx_full;
      logic rx_overrun;
      logic [31:0] arb_shift;
      logic [5:0] arb_left;
      logic ack;
      logic [31:0] rdata;
   } cmb_state_type;

   cmb_state_type state;
   cmb_state_type next_state;

   // ----------------------------------------------------------------------
   // Transmit buffer decode
   // ----------------------------------------------------------------------
   logic [7:0] tx_w0;
   logic [7:0] tx_w1;
   logic [7:0] tx_w2;
   logic [7:0] tx_w3;
   logic tx_ext;
   logic tx_remote;
   logic [28:0] tx_ident;
   logic [28:0] tx_key;
   logic [3:0] tx_code;
   logic [3:0] tx_count;
   logic [3:0] rx_count;
   logic [31:0] arb_load;
   logic [5:0] arb_len;

   assign tx_w0 = state.tx_buf[cmb_pkg::ID0_POS];
   assign tx_w1 = state.tx_buf[cmb_pkg::ID1_POS];
   assign tx_w2 = state.tx_buf[cmb_pkg::ID2_POS];
   assign tx_w3 = state.tx_buf[cmb_pkg::ID3_POS];
   assign tx_ext = tx_w1[cmb_pkg::IDE_BIT]; // [R11]
   assign tx_remote = tx_ext ? tx_w3[cmb_pkg::RTR_EXT_BIT]
                             : tx_w1[cmb_pkg::RTR_STD_BIT]; // [R06]
   // Extended: 8+3+3+8+7 bits, standard: 8+3 bits right aligned
   assign tx_ident = tx_ext ? {tx_w0, tx_w1[7:5], tx_w1[2:0], tx_w2, tx_w3[7:1]} // [R01] [R16] [R04] [R05]
                            : {18'h00000, tx_w0, tx_w1[7:5]}; // [R09] [R10]
   // Left aligned so that both formats compare on the bits sent first
   assign tx_key = tx_ext ? tx_ident : {tx_ident[10:0], 18'h00000};
   assign tx_code = state.tx_buf[cmb_pkg::LEN_POS][3:0];

   // Codes above eight still mean eight bytes
   assign tx_count = tx_remote ? 4'h0 // [R19]
                   : ((tx_code > cmb_pkg::MAX_COUNT) ? cmb_pkg::MAX_COUNT : tx_code); // [R14] [R18]
   assign rx_count = rx_remote_i ? 4'h0
                   : ((rx_len_code_i > cmb_pkg::MAX_COUNT) ? cmb_pkg::MAX_COUNT : rx_len_code_i);

   // Arbitration field: extended id, substitute, format, rest and remote bit; standard id, remote, format
   assign arb_load = tx_ext ? {tx_ident[28:18], tx_w1[cmb_pkg::SRR_BIT], 1'b1,
                               tx_ident[17:0], tx_remote} // [R02]
                            : {tx_ident[10:0], tx_remote, 1'b0, 19'h00000}; // [R08]
   assign arb_len = tx_ext ? cmb_pkg::ARB_LEN_EXT : cmb_pkg::ARB_LEN_STD;

   // ----------------------------------------------------------------------
   // Per byte payload gating
   // ----------------------------------------------------------------------
   logic [63:0] tx_payload;
   logic [7:0] rx_keep;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
         // Bytes past the count never leave the block
         assign tx_payload[gi*8 +: 8] = (4'(gi) < tx_count)
                                     ? state.tx_buf[4 + gi] : 8'h00; // [R15] [R13]
         assign rx_keep[gi] = (4'(gi) < rx_count); // [R14] [R15]
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic [5:0] idx;
   logic [3:0] off;
   logic in_tx;
   logic in_rx;
   logic bus_req;
   logic bus_wr;

   assign idx = adr_i[7:2];
   assign off = idx[3:0];
   assign in_tx = (idx[5:4] == cmb_pkg::TX_BASE_IDX[5:4]) && (off <= cmb_pkg::LAST_POS);
   assign in_rx = (idx[5:4] == cmb_pkg::RX_BASE_IDX[5:4]) && (off <= cmb_pkg::LAST_POS);
   assign bus_req = cyc_i && stb_i && !state.ack;
   assign bus_wr = bus_req && we_i && sel_i[0];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.ack = bus_req;

      // Read data
      next_state.rdata = 32'h00000000;
      if (bus_req && !we_i) begin
         if (in_tx) begin
            next_state.rdata = {24'h000000, state.tx_buf[off]};
         end else if (in_rx) begin
            next_state.rdata = {24'h000000, state.rx_buf[off]};
         end else if (idx == cmb_pkg::STAT_IDX) begin
            next_state.rdata[cmb_pkg::STAT_TX_PEND_BIT] = (state.tx_state == cmb_pkg::CMB_TX_PEND);
            next_state.rdata[cmb_pkg::STAT_RX_FULL_BIT] = state.rx_full;
            next_state.rdata[cmb_pkg::STAT_RX_OVR_BIT] = state.rx_overrun;
            next_state.rdata[cmb_pkg::STAT_TX_BUSY_BIT] = (state.tx_state == cmb_pkg::CMB_TX_BUSY);
         end
      end

      // Software writes; transmit buffer locked while queued or sending
      if (bus_wr) begin
         if (in_tx && state.tx_state == cmb_pkg::CMB_TX_IDLE) begin
            // Substitute bit is stored as written; software must write one
            next_state.tx_buf[off] = dat_i[7:0]; // [R17] [R13]
            if (off == cmb_pkg::LEN_POS) begin
               next_state.tx_buf[off] = {4'h0, dat_i[3:0]};
            end
         end else if (idx == cmb_pkg::CTRL_IDX) begin
            if (dat_i[cmb_pkg::CTRL_SEND_BIT] && state.tx_state == cmb_pkg::CMB_TX_IDLE) begin
               next_state.tx_state = cmb_pkg::CMB_TX_PEND;
            end else if (dat_i[cmb_pkg::CTRL_ABORT_BIT]
                         && state.tx_state == cmb_pkg::CMB_TX_PEND) begin
               next_state.tx_state = cmb_pkg::CMB_TX_IDLE;
            end
         end else if (idx == cmb_pkg::STAT_IDX) begin
            if (dat_i[cmb_pkg::STAT_RX_FULL_BIT]) begin
               next_state.rx_full = 1'b0;
            end
            if (dat_i[cmb_pkg::STAT_RX_OVR_BIT]) begin
               next_state.rx_overrun = 1'b0;
            end
         end
      end

      // Transmit hand-off to the engine
      unique case (state.tx_state)
         cmb_pkg::CMB_TX_IDLE: begin
         end
         cmb_pkg::CMB_TX_PEND: begin
            if (tx_take_i) begin
               next_state.tx_state = cmb_pkg::CMB_TX_BUSY;
               next_state.arb_shift = arb_load; // [R02] [R08]
               next_state.arb_left = arb_len;
            end
         end
         cmb_pkg::CMB_TX_BUSY: begin
            if (tx_done_i) begin
               next_state.tx_state = cmb_pkg::CMB_TX_IDLE;
            end
         end
         default: begin
            next_state.tx_state = cmb_pkg::CMB_TX_IDLE;
         end
      endcase

      // Most significant identifier bit goes out first
      if (arb_shift_i && state.arb_left != 6'h00) begin
         next_state.arb_shift = {state.arb_shift[30:0], 1'b0}; // [R02] [R08]
         next_state.arb_left = state.arb_left - 6'h01;
      end

      // Receive store; placed after the clear so that a new frame wins
      if (rx_store_i) begin
         // Full as seen after the clear above, so a clear frees the buffer at once
         if (next_state.rx_full) begin
            next_state.rx_overrun = 1'b1;
         end else begin
            next_state.rx_full = 1'b1;
            if (rx_ext_i) begin
               next_state.rx_buf[cmb_pkg::ID0_POS] = rx_ident_i[28:21]; // [R16] [R01]
               next_state.rx_buf[cmb_pkg::ID1_POS] = {rx_ident_i[20:18], rx_srr_i, 1'b1,
                                                      rx_ident_i[17:15]}; // [R17] [R12]
               next_state.rx_buf[cmb_pkg::ID2_POS] = rx_ident_i[14:7]; // [R04]
               next_state.rx_buf[cmb_pkg::ID3_POS] = {rx_ident_i[6:0], rx_remote_i}; // [R05] [R07]
            end else begin
               next_state.rx_buf[cmb_pkg::ID0_POS] = rx_ident_i[10:3]; // [R09]
               next_state.rx_buf[cmb_pkg::ID1_POS] = {rx_ident_i[2:0], rx_remote_i, 1'b0,
                                                      3'h0}; // [R10] [R07] [R12]
            end
            next_state.rx_buf[cmb_pkg::LEN_POS] = {4'h0, rx_len_code_i};
            for (int i = 0; i < 8; i++) begin
               if (rx_keep[i]) begin
                  next_state.rx_buf[4 + i] = rx_data_i[i*8 +: 8]; // [R13] [R14]
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= '0;
         state.tx_state <= cmb_pkg::CMB_TX_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign dat_o = state.rdata;
   assign ack_o = state.ack;
   assign tx_valid_o = (state.tx_state == cmb_pkg::CMB_TX_PEND);
   assign tx_ident_o = tx_ident;
   assign tx_ext_o = tx_ext;
   assign tx_remote_o = tx_remote;
   assign tx_srr_o = tx_w1[cmb_pkg::SRR_BIT];
   assign tx_len_code_o = tx_code; // [R19]
   assign tx_byte_count_o = tx_count;
   assign tx_data_o = tx_payload;
   assign tx_arb_key_o = tx_key;
   assign tx_outranks_o = (tx_key < contender_key_i); // [R03]
   assign arb_bit_o = state.arb_shift[31];
   assign arb_bits_left_o = state.arb_left;
   assign rx_ready_o = !state.rx_full;

endmodule

//--- tb/cmb_engine_model.sv
// Purpose: protocol engine stand-in for the message buffer
// Assumes: same clock as the buffer, pulses one cycle wide
// Notes: idle identifier, length and data lines carry inverted values; flag lines keep the last values sent
`timescale 1ns/1ps
module cmb_engine_model (
   // Clock
   input wire logic clk_i,
   // From the buffer
   input wire logic valid_i,
   input wire logic bit_i,
   input wire logic [5:0] left_i,
   // To the buffer
   output logic take_o = 1'b0,
   output logic done_o = 1'b0,
   output logic shift_o = 1'b0,
   output logic store_o = 1'b0,
   output logic [28:0] ident_o = 29'h0AAAAAAA,
   output logic ext_o = 1'b0,
   output logic remote_o = 1'b1,
   output logic srr_o = 1'b0,
   output logic [3:0] len_o = 4'hA,
   output logic [63:0] data_o = 64'h5555555555555555
);
   // Gap slows the shifting, as a busy bus would
   task automatic send(input int gap, output logic [31:0] f, output int n);
      int k;
      f = 32'h0;
      n = 0;
      k = 0;
      while (valid_i !== 1'b1 && k < 50) begin
         @(posedge clk_i);
         k++;
      end
      // Nothing queued: report an impossible count so the bench flags it
      if (valid_i !== 1'b1) begin
         n = -1;
         return;
      end
      take_o <= 1'b1;
      @(posedge clk_i);
      take_o <= 1'b0;
      @(posedge clk_i);
      while (left_i !== 6'h00 && n < 40) begin
         f = {f[30:0], bit_i};
         n++;
         shift_o <= 1'b1;
         @(posedge clk_i);
         shift_o <= 1'b0;
         repeat (gap + 1) @(posedge clk_i);
      end
      done_o <= 1'b1;
      @(posedge clk_i);
      done_o <= 1'b0;
   endtask
   task automatic recv(input logic [28:0] id, input logic e, r, s, input logic [3:0] l,
         input logic [63:0] d);
      ident_o <= id;
      ext_o <= e;
      remote_o <= r;
      srr_o <= s;
      len_o <= l;
      data_o <= d;
      store_o <= 1'b1;
      @(posedge clk_i);
      store_o <= 1'b0;
      ident_o <= ~id;
      len_o <= ~l;
      data_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule

//--- tb/cmb_message_buffer_assertions.sv
// Purpose: port checks for the message buffer
// Assumes: single clock, synchronous reset
// Notes: bound to the top module
`timescale 1ns/1ps
module cmb_message_buffer_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic tx_valid_o,
   input wire logic tx_take_i,
   input wire logic [28:0] tx_ident_o,
   input wire logic tx_ext_o,
   input wire logic tx_remote_o,
   input wire logic [3:0] tx_len_code_o,
   input wire logic [3:0] tx_byte_count_o,
   input wire logic [63:0] tx_data_o,
   input wire logic [28:0] tx_arb_key_o,
   input wire logic [28:0] contender_key_i,
   input wire logic tx_outranks_o,
   input wire logic arb_shift_i,
   input wire logic arb_bit_o,
   input wire logic [5:0] arb_bits_left_o,
   input wire logic rx_ready_o,
   input wire logic rx_store_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_take; tx_valid_o && tx_take_i |=> !tx_valid_o && arb_bit_o == tx_arb_key_o[28]
      && arb_bits_left_o == (tx_ext_o ? 6'h20 : 6'h0D); endproperty
   a_take: assert property (p_take) else $error("bad load");
   property p_shift; arb_shift_i && arb_bits_left_o != 6'h00 |=>
      arb_bits_left_o == $past(arb_bits_left_o) - 6'h01; endproperty
   a_shift: assert property (p_shift) else $error("bad shift");
   property p_rank; tx_outranks_o == (tx_arb_key_o < contender_key_i); endproperty
   a_rank: assert property (p_rank) else $error("bad rank");
   property p_key; tx_arb_key_o == (tx_ext_o ? tx_ident_o : {tx_ident_o[10:0], 18'h0});
   endproperty
   a_key: assert property (p_key) else $error("bad key");
   property p_count; tx_byte_count_o == (tx_remote_o ? 4'h0 :
      (tx_len_code_o > 4'h8 ? 4'h8 : tx_len_code_o)); endproperty
   a_count: assert property (p_count) else $error("bad count");
   property p_mask; tx_byte_count_o < 4'h8 |->
      (tx_data_o >> {tx_byte_count_o, 3'h0}) == 64'h0; endproperty
   a_mask: assert property (p_mask) else $error("extra bytes");
   property p_rx; rx_store_i && rx_ready_o |=> !rx_ready_o; endproperty
   a_rx: assert property (p_rx) else $error("no store");
   c_take: cover property (tx_valid_o && tx_take_i);
   c_over: cover property (rx_store_i && !rx_ready_o);
   c_rank: cover property (tx_outranks_o);
endmodule
bind cmb_message_buffer cmb_message_buffer_assertions cmb_message_buffer_assertions_i (
   .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .tx_valid_o, .tx_take_i, .tx_ident_o, .tx_ext_o,
   .tx_remote_o, .tx_len_code_o, .tx_byte_count_o, .tx_data_o, .tx_arb_key_o,
   .contender_key_i, .tx_outranks_o, .arb_shift_i, .arb_bit_o, .arb_bits_left_o,
   .rx_ready_o, .rx_store_i);

//--- tb/cmb_message_buffer_test.sv
// Purpose: self-checking bench for the message buffer
// Assumes: Wishbone master tasks, engine model beside the block
// Notes: buffers read zero after reset
`timescale 1ns/1ps
module cmb_message_buffer_test;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, r;
   logic [28:0] contender_key_i = 29'h1FFFFFFF, tx_ident_o, x, rid;
   logic [63:0] tx_data_o, rdat;
   logic [5:0] left;
   logic [3:0] tx_len_code_o, tx_byte_count_o, rlen;
   logic ack_o, tx_valid_o, tx_ext_o, tx_remote_o, tx_outranks_o, rx_ready_o, arb_bit;
   logic tx_srr_o;
   logic take, done, shift, store, rext, rrem, rsrr;
   int mismatches = 0, checks_done = 0;
   always #25 clk_i = ~clk_i;
   cmb_message_buffer cmb_message_buffer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .tx_valid_o(tx_valid_o), .tx_take_i(take), .tx_done_i(done),
      .tx_ident_o(tx_ident_o), .tx_ext_o(tx_ext_o), .tx_remote_o(tx_remote_o),
      .tx_srr_o(tx_srr_o),
      .tx_len_code_o(tx_len_code_o), .tx_byte_count_o(tx_byte_count_o), .tx_data_o(tx_data_o),
      .tx_arb_key_o(), .contender_key_i(contender_key_i), .tx_outranks_o(tx_outranks_o),
      .arb_shift_i(shift), .arb_bit_o(arb_bit), .arb_bits_left_o(left),
      .rx_ready_o(rx_ready_o), .rx_store_i(store), .rx_ident_i(rid), .rx_ext_i(rext),
      .rx_remote_i(rrem), .rx_srr_i(rsrr), .rx_len_code_i(rlen), .rx_data_i(rdat));
   cmb_engine_model eng_i (.clk_i(clk_i), .valid_i(tx_valid_o), .bit_i(arb_bit),
      .left_i(left), .take_o(take), .done_o(done), .shift_o(shift), .store_o(store),
      .ident_o(rid), .ext_o(rext), .remote_o(rrem), .srr_o(rsrr), .len_o(rlen), .data_o(rdat));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Holds the request until ack is sampled, then one idle cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'hF; dat_i <= {24'h0, d};
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      r = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      @(posedge clk_i);
      if (n >= 20) begin mismatches++; $display("[ERR] %0t no ack", $time); summarize(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e); bus(1'b0, a, 8'h00);
      chk(r, {24'h0, e}); endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      summarize();
   end
   initial begin
      logic [31:0] f;
      int n;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h84, 8'h00); rd(8'hFC, 8'h00);
      for (int i = 0; i < 10; i++) begin
         wr(8'h30, 8'(i));
         chk(tx_byte_count_o, (i > 8) ? 8 : i);
      end
      wr(8'h00, 8'hA5); wr(8'h04, 8'h60); wr(8'h30, 8'h05);
      for (int i = 0; i < 8; i++) wr(8'(8'h10 + 4 * i), 8'(8'h11 * (i + 1)));
      chk(tx_ident_o, 29'h52B); chk({tx_ext_o, tx_remote_o}, 0);
      chk(tx_data_o, 64'h0000005544332211);
      wr(8'h80, 8'h01); wr(8'h00, 8'hFF); rd(8'h00, 8'hA5); rd(8'h84, 8'h01);
      contender_key_i <= {11'h52B, 18'h00001}; @(posedge clk_i); chk(tx_outranks_o, 1);
      contender_key_i <= {11'h52A, 18'h3FFFF}; @(posedge clk_i); chk(tx_outranks_o, 0);
      eng_i.send(0, f, n); chk(f, {21'h0, 11'h52B} << 2); chk(n, 13);
      x = 29'h1234ABCD;
      wr(8'h00, x[28:21]); wr(8'h04, {x[20:18], 2'b11, x[17:15]});
      wr(8'h08, x[14:7]); wr(8'h0C, {x[6:0], 1'b1}); wr(8'h30, 8'h0F);
      chk(tx_ident_o, x); chk(tx_byte_count_o, 0); chk(tx_len_code_o, 4'hF);
      chk({tx_ext_o, tx_remote_o, tx_srr_o}, 3'h7);
      contender_key_i <= x + 29'h1; @(posedge clk_i); chk(tx_outranks_o, 1);
      contender_key_i <= x; @(posedge clk_i); chk(tx_outranks_o, 0);
      wr(8'h80, 8'h01); wr(8'h80, 8'h02); rd(8'h84, 8'h00); wr(8'h80, 8'h01);
      eng_i.send(2, f, n); chk(f, {x[28:18], 2'b11, x[17:0], 1'b1}); chk(n, 32);
      eng_i.recv(x, 1'b1, 1'b0, 1'b1, 4'h3, 64'h8877665544332211);
      chk(rx_ready_o, 0); rd(8'h84, 8'h02); rd(8'h40, x[28:21]); rd(8'h48, x[14:7]);
      rd(8'h44, {x[20:18], 2'b11, x[17:15]}); rd(8'h4C, {x[6:0], 1'b0});
      rd(8'h50, 8'h11); rd(8'h58, 8'h33); rd(8'h5C, 8'h00); rd(8'h70, 8'h03);
      eng_i.recv(29'h7FF, 1'b0, 1'b1, 1'b1, 4'h2, 64'h0); rd(8'h84, 8'h06); rd(8'h40, x[28:21]);
      // Clear and a new frame in one cycle: the frame is kept
      fork
         wr(8'h84, 8'h06);
         eng_i.recv(29'h3C5, 1'b0, 1'b1, 1'b1, 4'h4, 64'h0);
      join
      rd(8'h84, 8'h02); chk(rx_ready_o, 0);
      wr(8'h84, 8'h06); rd(8'h84, 8'h00); chk(rx_ready_o, 1);
      rd(8'h40, 8'h78); rd(8'h44, 8'hB0); rd(8'h70, 8'h04); rd(8'h50, 8'h11);
      summarize();
   end
endmodule
